// File: trace_alarm_pkg.sv
package trace_alarm_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_ENABLE     = 8'h20;
    localparam logic [7:0] IDX_STATUS     = 8'h21;
    localparam logic [7:0] IDX_IND_ADDR   = 8'h22;
    localparam logic [7:0] IDX_IND_DATA   = 8'h23;
    localparam logic [7:0] IDX_MODE       = 8'h30;
    localparam logic [7:0] ADDR_ENABLE    = {IDX_ENABLE[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATUS    = {IDX_STATUS[5:0], 2'b00};
    localparam logic [7:0] ADDR_MODE      = {IDX_MODE[5:0], 2'b00};
    localparam logic [7:0] ADDR_IND_ADDR  = {IDX_IND_ADDR[5:0], 2'b00};
    localparam logic [7:0] ADDR_IND_DATA  = {IDX_IND_DATA[5:0], 2'b00};

    // Trace control field positions (map 0, offset 20h)
    localparam int BIT_BUF_SIDE     = 6;
    localparam int BIT_UNSTABLE_EN  = 5;
    localparam int BIT_MISMATCH_EN  = 4;
    localparam int BIT_PERSIST      = 3;
    localparam int BIT_TNULL        = 2;

    // Trace status field positions (map 0, offset 21h)
    localparam int BIT_BUSY         = 7;
    localparam int BIT_UNST_EVENT   = 3;
    localparam int BIT_UNST_STATE   = 2;
    localparam int BIT_MISM_EVENT   = 1;
    localparam int BIT_MISM_STATE   = 0;

    // Line alarm field positions (map 1, offsets 20h and 21h)
    localparam int BIT_PBF_EN       = 7;
    localparam int BIT_APS_EN       = 6;
    localparam int BIT_SYNC_EN      = 5;
    localparam int BIT_FAIL_EN      = 4;
    localparam int BIT_DEGR_EN      = 3;
    localparam int BIT_FAIL_STATE   = 2;
    localparam int BIT_DEGR_STATE   = 1;
    localparam int BIT_PBF_STATE    = 0;

    // Reset values
    localparam logic [7:0] TRACE_CTRL_RST = 8'h04;
    localparam logic [7:0] ALARM_EN_RST   = 8'h00;

    // Counts
    localparam logic [3:0] UNSTABLE_COUNT = 4'h8;
    localparam logic [3:0] PERSIST_SHORT  = 4'h3;
    localparam logic [3:0] PERSIST_LONG   = 4'h5;
    localparam logic [3:0] PBF_DECLARE    = 4'hc;
    localparam logic [3:0] PBF_REMOVE     = 4'h3;
    localparam logic [2:0] ACCESS_CYCLES  = 3'h4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_s;

    // Line-side events, one-cycle pulses from the overhead processors
    typedef struct packed {
        logic       traceNew;      // a trace message has been received
        logic       traceSame;     // it equals the previous message
        logic       traceExpMatch; // candidate equals expected message
        logic       frameK1;       // a frame boundary with K1 sampled
        logic [7:0] k1Byte;
        logic       degradeSet;
        logic       degradeClr;
        logic       failSet;
        logic       failClr;
        logic       syncCaptured;
        logic       apsCaptured;
    } line_in_s;

endpackage : trace_alarm_pkg

// File: trace_and_line_alarm_status.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module trace_and_line_alarm_status
    import trace_alarm_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire trace_alarm_pkg::axi_req_s axiReq,
    output var   trace_alarm_pkg::axi_rsp_s axiRsp,
    input  wire trace_alarm_pkg::line_in_s lineIn,
    output logic                           interrupt_out_n,
    output logic                           bufAccessStart,
    output logic                           bufReadNotWrite,
    output logic [7:0]                     bufAddress,
    output logic                           bufReceiveSide,
    output logic [7:0]                     bufWriteData,
    input  wire logic                      bufDone,
    input  wire logic [7:0]                bufReadData
);
    import trace_alarm_pkg::*;

    typedef struct packed {
        logic       awHeld;
        logic [7:0] awAddr;
        logic       wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        axi_rsp_s   rsp;
        logic       extendedMap;
        logic [7:0] traceCtrl;
        logic [7:0] alarmEn;
        logic [7:0] indAddr;
        logic [7:0] indData;
        logic       busy;
        logic       accStart;
        logic [2:0] accCnt;
        logic [3:0] diffCnt;
        logic [3:0] sameCnt;
        logic       unstable;
        logic       mismatch;
        logic       mismEvent;
        logic       unstEvent;
        logic [7:0] k1Prev;
        logic [3:0] k1Same;
        logic [3:0] pbfCnt;
        logic       pbf;
        logic       degrade;
        logic       fail;
        logic       degrEvent;
        logic       failEvent;
        logic       syncEvent;
        logic       apsEvent;
        logic       pbfEvent;
        logic       irqN;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;
    logic   rstSync1_r;
    logic   rstSync2_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end

    function automatic logic [3:0] satInc(input logic [3:0] v);
        satInc = (v == 4'hf) ? v : v + 4'h1;
    endfunction : satInc

    function automatic logic [31:0] readMux(input state_s s,
                                            input logic [7:0] a);
        readMux = 32'h0;
        unique case (a)
            ADDR_ENABLE:
                readMux[7:0] = s.extendedMap ? s.alarmEn : s.traceCtrl;
            ADDR_STATUS: begin
                if (s.extendedMap) begin
                    readMux[BIT_PBF_EN]     = s.pbfEvent;
                    readMux[BIT_APS_EN]     = s.apsEvent;
                    readMux[BIT_SYNC_EN]    = s.syncEvent;
                    readMux[BIT_FAIL_EN]    = s.failEvent;
                    readMux[BIT_DEGR_EN]    = s.degrEvent;
                    readMux[BIT_FAIL_STATE] = s.fail;
                    readMux[BIT_DEGR_STATE] = s.degrade;
                    readMux[BIT_PBF_STATE]  = s.pbf;
                end else begin
                    readMux[BIT_BUSY]       = s.busy;
                    readMux[BIT_UNST_EVENT] = s.unstEvent;
                    readMux[BIT_UNST_STATE] = s.unstable;
                    readMux[BIT_MISM_EVENT] = s.mismEvent;
                    readMux[BIT_MISM_STATE] = s.mismatch;
                end
            end
            ADDR_MODE:     readMux[0]   = s.extendedMap;
            ADDR_IND_ADDR: readMux[7:0] = s.indAddr;
            ADDR_IND_DATA: readMux[7:0] = s.indData;
            default:       readMux      = 32'h0;
        endcase
    endfunction : readMux

    // Any enabled event still latched keeps the interrupt asserted
    function automatic logic pendingIrq(input state_s s);
        logic traceIrq;
        logic alarmIrq;
        traceIrq = (s.unstEvent && s.traceCtrl[BIT_UNSTABLE_EN]) ||
                   (s.mismEvent && s.traceCtrl[BIT_MISMATCH_EN]);
        alarmIrq = (s.degrEvent && s.alarmEn[BIT_DEGR_EN]) ||
                   (s.failEvent && s.alarmEn[BIT_FAIL_EN]) ||
                   (s.syncEvent && s.alarmEn[BIT_SYNC_EN]) ||
                   (s.apsEvent  && s.alarmEn[BIT_APS_EN]) ||
                   (s.pbfEvent  && s.alarmEn[BIT_PBF_EN]);
        pendingIrq = traceIrq || alarmIrq;
    endfunction : pendingIrq

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_ENABLE) || (a == ADDR_STATUS) ||
                 (a == ADDR_MODE) || (a == ADDR_IND_ADDR) ||
                 (a == ADDR_IND_DATA);
    endfunction : mapped

    logic       doWrite;
    logic       doRead;
    logic       readTrace;
    logic       readAlarm;
    logic       unstNew;
    logic       mismNew;
    logic       pbfNew;
    logic       degrNew;
    logic       failNew;
    logic [3:0] acceptCnt;

    always_comb begin
        cur_nxt = cur_r;
        doWrite = 1'b0;
        doRead  = 1'b0;
        readTrace = 1'b0;
        readAlarm = 1'b0;
        cur_nxt.accStart = 1'b0;

        // Write address and data taken in either order
        if (axiReq.awvalid && cur_r.rsp.awready) begin
            cur_nxt.awHeld = 1'b1;
            cur_nxt.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && cur_r.rsp.wready) begin
            cur_nxt.wHeld = 1'b1;
            cur_nxt.wData = axiReq.wdata;
            cur_nxt.wStrb = axiReq.wstrb;
        end
        if (cur_r.awHeld && cur_r.wHeld && !cur_r.rsp.bvalid) begin
            doWrite = cur_r.wStrb[0];
            cur_nxt.rsp.bvalid = 1'b1;
            cur_nxt.rsp.bresp  = mapped(cur_r.awAddr) ? RESP_OKAY
                                                       : RESP_SLVERR;
            cur_nxt.awHeld = 1'b0;
            cur_nxt.wHeld  = 1'b0;
        end
        if (cur_r.rsp.bvalid && axiReq.bready)
            cur_nxt.rsp.bvalid = 1'b0;
        cur_nxt.rsp.awready = !cur_nxt.awHeld && !cur_nxt.rsp.bvalid;
        cur_nxt.rsp.wready  = !cur_nxt.wHeld && !cur_nxt.rsp.bvalid;

        if (axiReq.arvalid && cur_r.rsp.arready) begin
            doRead = 1'b1;
            cur_nxt.rsp.rvalid = 1'b1;
            cur_nxt.rsp.rdata  = readMux(cur_r, axiReq.araddr);
            cur_nxt.rsp.rresp  = mapped(axiReq.araddr) ? RESP_OKAY
                                                        : RESP_SLVERR;
            readTrace = (axiReq.araddr == ADDR_STATUS) && !cur_r.extendedMap;
            readAlarm = (axiReq.araddr == ADDR_STATUS) && cur_r.extendedMap;
        end
        if (cur_r.rsp.rvalid && axiReq.rready)
            cur_nxt.rsp.rvalid = 1'b0;
        cur_nxt.rsp.arready = !cur_nxt.rsp.rvalid;

        if (doWrite) begin
            unique case (cur_r.awAddr)
                ADDR_ENABLE: begin
                    if (cur_r.extendedMap)
                        cur_nxt.alarmEn = cur_r.wData[7:0];
                    else
                        cur_nxt.traceCtrl = cur_r.wData[7:0];
                end
                ADDR_MODE:
                    cur_nxt.extendedMap = cur_r.wData[0];
                ADDR_IND_ADDR: begin
                    cur_nxt.indAddr  = cur_r.wData[7:0];
                    cur_nxt.busy     = 1'b1;
                    cur_nxt.accStart = 1'b1;
                    cur_nxt.accCnt   = ACCESS_CYCLES;
                end
                ADDR_IND_DATA:
                    cur_nxt.indData = cur_r.wData[7:0];
                default: ;
            endcase
        end

        // Indirect access ends on done, or after a fixed wait
        if (cur_r.busy && !cur_r.accStart) begin
            if (cur_r.accCnt != 3'h0)
                cur_nxt.accCnt = cur_r.accCnt - 3'h1;
            if (bufDone || cur_r.accCnt == 3'h0) begin
                cur_nxt.busy = 1'b0;
                if (cur_r.indAddr[7])
                    cur_nxt.indData = bufReadData;
            end
        end

        // Trace message persistence and stability
        acceptCnt = cur_r.traceCtrl[BIT_PERSIST] ? PERSIST_LONG
                                                 : PERSIST_SHORT;
        if (lineIn.traceNew) begin
            if (lineIn.traceSame) begin
                cur_nxt.diffCnt = 4'h0;
                cur_nxt.sameCnt = satInc(cur_r.sameCnt);
                // Compare repeats, so a saturated count cannot wrap
                if (satInc(cur_r.sameCnt) >= acceptCnt - 4'h1) begin
                    cur_nxt.unstable = 1'b0;
                    cur_nxt.mismatch = !lineIn.traceExpMatch;
                end
            end else begin
                cur_nxt.sameCnt = 4'h0;
                cur_nxt.diffCnt = satInc(cur_r.diffCnt);
                if (satInc(cur_r.diffCnt) >= UNSTABLE_COUNT)
                    cur_nxt.unstable = 1'b1;
            end
        end
        unstNew = cur_nxt.unstable != cur_r.unstable;
        mismNew = cur_nxt.mismatch != cur_r.mismatch;
        if (readTrace) begin
            cur_nxt.unstEvent = 1'b0;
            cur_nxt.mismEvent = 1'b0;
        end
        if (unstNew)
            cur_nxt.unstEvent = 1'b1;
        if (mismNew)
            cur_nxt.mismEvent = 1'b1;

        // Protection byte failure on K1 consistency
        if (lineIn.frameK1) begin
            cur_nxt.k1Prev = lineIn.k1Byte;
            if (lineIn.k1Byte == cur_r.k1Prev)
                cur_nxt.k1Same = satInc(cur_r.k1Same);
            else
                cur_nxt.k1Same = 4'h1;
            if (cur_nxt.k1Same >= PBF_REMOVE) begin
                cur_nxt.pbfCnt = 4'h0;
                cur_nxt.pbf    = 1'b0;
            end else begin
                cur_nxt.pbfCnt = satInc(cur_r.pbfCnt);
                if (satInc(cur_r.pbfCnt) >= PBF_DECLARE)
                    cur_nxt.pbf = 1'b1;
            end
        end

        // Threshold crossing states
        if (lineIn.degradeSet)
            cur_nxt.degrade = 1'b1;
        else if (lineIn.degradeClr)
            cur_nxt.degrade = 1'b0;
        if (lineIn.failSet)
            cur_nxt.fail = 1'b1;
        else if (lineIn.failClr)
            cur_nxt.fail = 1'b0;
        pbfNew  = cur_nxt.pbf != cur_r.pbf;
        degrNew = cur_nxt.degrade != cur_r.degrade;
        failNew = cur_nxt.fail != cur_r.fail;

        if (readAlarm) begin
            cur_nxt.degrEvent = 1'b0;
            cur_nxt.failEvent = 1'b0;
            cur_nxt.syncEvent = 1'b0;
            cur_nxt.apsEvent  = 1'b0;
            cur_nxt.pbfEvent  = 1'b0;
        end
        if (degrNew)
            cur_nxt.degrEvent = 1'b1;
        if (failNew)
            cur_nxt.failEvent = 1'b1;
        if (lineIn.syncCaptured)
            cur_nxt.syncEvent = 1'b1;
        if (lineIn.apsCaptured)
            cur_nxt.apsEvent = 1'b1;
        if (pbfNew)
            cur_nxt.pbfEvent = 1'b1;

        cur_nxt.irqN = !pendingIrq(cur_nxt);
    end

    always_ff @(posedge clk or negedge rstSync2_r) begin
        if (!rstSync2_r) begin
            cur_r             <= '0;
            cur_r.traceCtrl   <= TRACE_CTRL_RST;
            cur_r.alarmEn     <= ALARM_EN_RST;
            cur_r.rsp.awready <= 1'b1;
            cur_r.rsp.wready  <= 1'b1;
            cur_r.rsp.arready <= 1'b1;
            cur_r.irqN        <= 1'b1;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign axiRsp          = cur_r.rsp;
    assign interrupt_out_n = cur_r.irqN;
    assign bufAccessStart  = cur_r.accStart;
    assign bufReadNotWrite = cur_r.indAddr[7];
    assign bufAddress      = {1'b0, cur_r.indAddr[6:0]};
    assign bufReceiveSide  = cur_r.traceCtrl[BIT_BUF_SIDE];
    assign bufWriteData    = cur_r.indData;

endmodule : trace_and_line_alarm_status

`default_nettype wire

// File: trace_alarm_sva.sv
`timescale 1ns/1ns
`default_nettype none
module trace_alarm_sva
    import trace_alarm_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      reset_n,
    input wire trace_alarm_pkg::axi_req_s axiReq,
    input wire trace_alarm_pkg::axi_rsp_s axiRsp,
    input wire trace_alarm_pkg::line_in_s lineIn,
    input wire logic                      interrupt_out_n,
    input wire logic                      bufAccessStart,
    input wire logic                      bufReadNotWrite,
    input wire logic [7:0]                bufAddress,
    input wire logic                      bufReceiveSide,
    input wire logic [7:0]                bufWriteData,
    input wire logic                      bufDone,
    input wire logic [7:0]                bufReadData
);
    logic [2:0] busHist_r;
    logic [1:0] lineHist_r;
    logic       busNow;
    logic       busRecent;
    logic       lineRecent;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Recent bus and line activity, the only causes of interrupt changes
    assign busNow = axiReq.awvalid | axiReq.wvalid | axiReq.arvalid
                  | axiRsp.bvalid | axiRsp.rvalid;
    assign busRecent = busNow | (|busHist_r);
    assign lineRecent = |lineHist_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busHist_r  <= 3'h0;
            lineHist_r <= 2'h0;
        end else begin
            busHist_r  <= {busHist_r[1:0], busNow};
            lineHist_r <= {lineHist_r[0], (|lineIn[17:14]) | (|lineIn[5:0])};
        end
    end
    property p_bhold;
        axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold;
        axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    property p_wlat;
        axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
            |-> ##[1:2] axiRsp.bvalid;
    endproperty
    a_wlat: assert property (p_wlat) else $error("write answer late");
    property p_rlat;
        axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_upper;
        axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_pulse;
        bufAccessStart |=> !bufAccessStart;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start not a pulse");
    property p_start;
        bufAccessStart |-> busRecent;
    endproperty
    a_start: assert property (p_start) else $error("start without write");
    property p_irqfall;
        $fell(interrupt_out_n) |-> lineRecent || busRecent;
    endproperty
    a_irqfall: assert property (p_irqfall) else $error("irq without cause");
    property p_irqrise;
        $rose(interrupt_out_n) |-> busRecent;
    endproperty
    a_irqrise: assert property (p_irqrise) else $error("irq freed early");
    property p_irqhold;
        !interrupt_out_n && !busRecent |=> !interrupt_out_n;
    endproperty
    a_irqhold: assert property (p_irqhold) else $error("irq not held");
endmodule : trace_alarm_sva
bind trace_and_line_alarm_status trace_alarm_sva trace_alarm_sva_i (
    .clk(clk), .reset_n(reset_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .lineIn(lineIn), .interrupt_out_n(interrupt_out_n),
    .bufAccessStart(bufAccessStart), .bufReadNotWrite(bufReadNotWrite),
    .bufAddress(bufAddress), .bufReceiveSide(bufReceiveSide),
    .bufWriteData(bufWriteData), .bufDone(bufDone), .bufReadData(bufReadData));
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import trace_alarm_pkg::*;
    logic        clk;
    logic        reset_n;
    axi_req_s    axiReq;
    axi_rsp_s    axiRsp;
    line_in_s    lineIn;
    logic        interrupt_out_n;
    logic        bufAccessStart;
    logic        bufReadNotWrite;
    logic [7:0]  bufAddress;
    logic        bufReceiveSide;
    logic [7:0]  bufWriteData;
    logic        bufDone = 1'b0;
    logic [7:0]  bufReadData;
    logic [1:0]  dly = 2'd0;
    logic [17:0] expBuf;
    logic [67:0] expQ[$];
    logic [67:0] note;
    logic [31:0] rnd;
    int          miscompares;
    int          nTests;
    int          kPos[6] = '{5, 3, 1, 0, 4, 2};
    int          stPos[6] = '{3, 4, 5, 6, 3, 4};
    logic [1:0]  st[6] = '{2'b01, 2'b11, 2'b11, 2'b11, 2'b10, 2'b00};
    trace_and_line_alarm_status trace_and_line_alarm_status_i (
        .clk(clk), .reset_n(reset_n), .axiReq(axiReq), .axiRsp(axiRsp),
        .lineIn(lineIn), .interrupt_out_n(interrupt_out_n),
        .bufAccessStart(bufAccessStart), .bufReadNotWrite(bufReadNotWrite),
        .bufAddress(bufAddress), .bufReceiveSide(bufReceiveSide),
        .bufWriteData(bufWriteData), .bufDone(bufDone),
        .bufReadData(bufReadData));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        nTests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'h1;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (axiRsp.bvalid !== 1'b1);
        axiReq.bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e,
                      input logic [33:0] m);
        expQ.push_back({m, e});
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (axiRsp.rvalid !== 1'b1);
        axiReq.rready <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic line_pulse(input line_in_s v);
        lineIn <= v;
        @(posedge clk);
        lineIn <= '0;
        repeat (3) @(posedge clk);
    endtask : line_pulse
    task automatic trace_msgs(input logic s, input logic m, input int n);
        repeat (n) line_pulse('{traceNew: 1'b1, traceSame: s,
                                traceExpMatch: m, default: '0});
    endtask : trace_msgs
    // Read results are compared against the oldest note
    always @(posedge clk) begin
        if (axiRsp.rvalid === 1'b1 && axiReq.rready === 1'b1) begin
            note = expQ.pop_front();
            check({axiRsp.rresp, axiRsp.rdata} & note[67:34], note[33:0]);
        end
    end
    // Buffer side answers three cycles after each access start
    always @(posedge clk) begin
        if (bufAccessStart === 1'b1) begin
            check(34'({bufReceiveSide, bufReadNotWrite, bufAddress, bufWriteData}), 34'(expBuf));
            dly <= 2'd3;
        end else if (dly != 2'd0) begin
            dly <= dly - 2'd1;
        end
        bufDone <= (dly == 2'd1);
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
    initial begin
        axiReq = '0;
        lineIn = '0;
        bufReadData = 8'h0;
        expBuf = '0;
        miscompares = 0;
        nTests = 0;
        reset_n = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rnd = $urandom(32'ha0aa);
        rnd = $urandom;
        rd(ADDR_ENABLE, 34'(TRACE_CTRL_RST), 34'h7f);
        rd(ADDR_STATUS, 34'h0, 34'h80);
        rd(8'h90, {RESP_SLVERR, 32'h0}, 34'h3_ffff_ffff);
        wr(ADDR_MODE, 32'h1);
        rd(ADDR_ENABLE, 34'(ALARM_EN_RST), 34'hf8);
        wr(ADDR_ENABLE, {24'h0, rnd[7:0]});
        rd(ADDR_ENABLE, {26'h0, rnd[7:0]}, 34'hff);
        rd(ADDR_STATUS, 34'h0, 34'h0);
        $display("test map done");
        wr(ADDR_ENABLE, 32'hf8);
        for (int i = 0; i < 6; i++) begin
            line_pulse(line_in_s'(18'h1 << kPos[i]));
            check(34'(interrupt_out_n), 34'h0);
            rd(ADDR_STATUS, 34'((8'h1 << stPos[i]) | {5'h0, st[i], 1'b0}), 34'h3_ffff_ffff);
            check(34'(interrupt_out_n), 34'h1);
        end
        wr(ADDR_ENABLE, 32'h0);
        line_pulse('{syncCaptured: 1'b1, default: '0});
        check(34'(interrupt_out_n), 34'h1);
        rd(ADDR_STATUS, 34'h20, 34'hff);
        $display("test alarms done");
        wr(ADDR_ENABLE, 32'h80);
        for (int i = 0; i < 12; i++) begin
            if (i == 11) rd(ADDR_STATUS, 34'h0, 34'h1);
            line_pulse('{frameK1: 1'b1, k1Byte: 8'(i), default: '0});
        end
        check(34'(interrupt_out_n), 34'h0);
        rd(ADDR_STATUS, 34'h81, 34'hff);
        for (int i = 0; i < 3; i++) begin
            if (i == 2) rd(ADDR_STATUS, 34'h1, 34'h1);
            line_pulse('{frameK1: 1'b1, k1Byte: rnd[7:0] | 8'h80, default: '0});
        end
        rd(ADDR_STATUS, 34'h80, 34'hff);
        $display("test byte fail done");
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_ENABLE, 32'h34);
        rd(ADDR_STATUS, 34'h0, 34'h80);
        trace_msgs(1'b0, 1'b0, 7);
        rd(ADDR_STATUS, 34'h0, 34'h04);
        trace_msgs(1'b0, 1'b0, 1);
        check(34'(interrupt_out_n), 34'h0);
        rd(ADDR_STATUS, 34'h0c, 34'h0c);
        check(34'(interrupt_out_n), 34'h1);
        trace_msgs(1'b1, 1'b0, 1);
        rd(ADDR_STATUS, 34'h04, 34'h04);
        trace_msgs(1'b1, 1'b0, 1);
        rd(ADDR_STATUS, 34'h09, 34'h0d);
        wr(ADDR_ENABLE, 32'h3c);
        trace_msgs(1'b0, 1'b1, 8);
        rd(ADDR_STATUS, 34'h04, 34'h04);
        trace_msgs(1'b1, 1'b1, 3);
        rd(ADDR_STATUS, 34'h04, 34'h04);
        trace_msgs(1'b1, 1'b1, 1);
        check(34'(interrupt_out_n), 34'h0);
        rd(ADDR_STATUS, 34'h0a, 34'h0f);
        $display("test trace done");
        wr(ADDR_ENABLE, 32'h44);
        wr(ADDR_IND_DATA, {24'h0, rnd[15:8]});
        expBuf = {2'b11, 8'h05, rnd[15:8]};
        bufReadData <= rnd[23:16];
        wr(ADDR_IND_ADDR, 32'h85);
        rd(ADDR_STATUS, 34'h80, 34'h80);
        repeat (8) @(posedge clk);
        // Busy is read once after a fixed 8-cycle wait and checked low before the data is used
        rd(ADDR_STATUS, 34'h0, 34'h80);
        rd(ADDR_IND_DATA, 34'(rnd[23:16]), 34'hff);
        wr(ADDR_ENABLE, 32'h04);
        expBuf = {2'b00, 8'h3f, rnd[23:16]};
        wr(ADDR_IND_ADDR, 32'h3f);
        repeat (8) @(posedge clk);
        rd(ADDR_STATUS, 34'h0, 34'h80);
        $display("test buffer done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
